// *** shared/osr_pkg.sv ***
// Constants and types of the maintenance status register bank.
// Assumes a 32-bit AXI4-Lite slave port, one register per aligned word.
package osr_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index.
  localparam logic [7:0] OSR_IDX_SHADOW = 8'h4f;
  localparam logic [7:0] OSR_IDX_LOC_STAT_LOW = 8'h50;
  localparam logic [7:0] OSR_IDX_LOC_STAT_HIGH = 8'h51;
  localparam logic [7:0] OSR_IDX_LOC_VENDOR0 = 8'h52;
  localparam logic [7:0] OSR_IDX_LOC_VENDOR1 = 8'h53;
  localparam logic [7:0] OSR_IDX_LOC_VENDOR2 = 8'h54;
  localparam logic [7:0] OSR_IDX_LOC_MODEL0 = 8'h55;
  localparam logic [7:0] OSR_IDX_LOC_MODEL1 = 8'h56;
  localparam logic [7:0] OSR_IDX_LOC_MODEL2 = 8'h57;
  localparam logic [7:0] OSR_IDX_PART_STAT_LOW = 8'h58;
  localparam logic [7:0] OSR_IDX_PART_STAT_HIGH = 8'h59;
  localparam logic [7:0] OSR_IDX_PART_VENDOR0 = 8'h5a;
  localparam logic [7:0] OSR_IDX_PART_VENDOR1 = 8'h5b;
  localparam logic [7:0] OSR_IDX_PART_VENDOR2 = 8'h5c;
  localparam logic [7:0] OSR_IDX_PART_MODEL0 = 8'h5d;
  localparam logic [7:0] OSR_IDX_PART_MODEL1 = 8'h5e;
  localparam logic [7:0] OSR_IDX_PART_MODEL2 = 8'h5f;

  // ==========================================================================
  // Field positions of the two status words.
  localparam int OSR_BIT_ROLE = 6;
  localparam int OSR_BIT_LOOPBACK = 5;
  localparam int OSR_BIT_NOTIFY_SEL = 4;
  localparam int OSR_BIT_DIAG_FAIL = 3;
  localparam int OSR_BIT_LINK_DOWN = 2;
  localparam int OSR_BIT_SIG_ABSENT = 1;
  localparam int OSR_BIT_POWER_DOWN = 0;
  localparam int OSR_BIT_MULTI_PHY = 3;
  localparam int OSR_BIT_AUTONEG = 2;
  localparam int OSR_BIT_DUPLEX = 1;
  localparam int OSR_BIT_SPEED = 0;

  // ==========================================================================
  // Reset values and write masks.
  localparam logic [7:0] OSR_LOC_LOW_RST = 8'h06;
  localparam logic [7:0] OSR_LOC_HIGH_RST = 8'h00;
  localparam logic [7:0] OSR_PART_LOW_RST_CENTER = 8'h47;
  localparam logic [7:0] OSR_PART_LOW_RST_TERMINAL = 8'h07;
  localparam logic [7:0] OSR_PART_HIGH_RST = 8'h00;
  localparam logic [23:0] OSR_INFO_RST = 24'h000000;
  localparam logic [7:0] OSR_LOW_WMASK_CENTER = 8'h1c;
  localparam logic [7:0] OSR_HIGH_WMASK = 8'h0c;
  localparam logic [1:0] OSR_RESP_OKAY = 2'b00;
  localparam logic [1:0] OSR_RESP_SLVERR = 2'b10;

  // ==========================================================================
  // Maintenance frame fields carried between this bank and the frame engine.
  typedef struct packed {
    logic [7:0] status_high;
    logic [7:0] status_low;
    logic [23:0] vendor;
    logic [23:0] model;
  } osr_frame_type;

  typedef struct packed {
    logic init_done;
    logic role_terminal;
    logic [7:0] stat_low;
    logic [7:0] stat_high;
    logic [23:0] vendor;
    logic [23:0] model;
    logic [7:0] part_low;
    logic [7:0] part_high;
    logic [23:0] part_vendor;
    logic [23:0] part_model;
    logic [7:0] shadow;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    osr_frame_type tx_frame;
  } osr_state_type;

endpackage : osr_pkg

// *** core/osr_regs.sv ***
// Local and partner maintenance status register bank with AXI4-Lite access.
// Assumes all pin inputs are synchronous to core_clk_i and that the frame
// engine presents each valid received maintenance frame as a one-cycle pulse.
//
// Function
// RULE1: status-low bit 6 reads 1 in terminal role, 0 in center role.
// RULE2: status-low bit 5 reads 1 in loopback, 0 in normal operation.
// RULE3: status-low bit 4 selects loss signalling: 1 far-end fault, 0 frame.
// RULE4: Center software writes the loss-notify bit; terminal hardware copies the pin.
// RULE5: Bit 3 flags diagnostic failure; terminal follows pin, reset equals pin.
// RULE6: Bit 2 reads 1 when copper link is down; resets to 1.
// RULE7: Copper-down bit is hardware-owned in terminal role, software-written in center.
// RULE8: Bit 1 reads 1 when no optical signal; resets to 1.
// RULE9: Bit 0 reads 1 when powered down; resets to inverse of pin.
// RULE10: Status-high bits 7..4 read 0; bit 3 is writable multi-interface flag.
// RULE11: Status-high bit 2 is autoneg support; terminal resets to strap, center 0.
// RULE12: Terminal duplex bit reads full duplex, forced 0 while copper link down.
// RULE13: Terminal speed bit reads 100 Mbps, forced 0 while copper link down.
// RULE14: Center role reads duplex and speed bits as 0 always.
// RULE15: Software avoids four reserved model-byte values when remote command used.
// RULE16: Partner status-low is read-only; resets 0x47 center, 0x07 terminal.
// RULE17: Partner status-high is read-only and resets to 0x00.
// RULE18: Shadow register mirrors partner status-low while optical link is up.
// RULE19: Partner vendor and model bytes load from each valid received frame.
// RULE20: Local status, vendor and model bytes feed every transmitted frame.
`timescale 1ns/1ps
module osr_regs (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Device pins and straps
  input wire logic role_terminal_i,
  input wire logic loopback_state_i,
  input wire logic optical_loss_notify_pin_i,
  input wire logic diagnostic_fail_pin_i,
  input wire logic power_down_pin_n_i,
  input wire logic copper_autoneg_strap_i,
  // Link state from the copper and optical ports
  input wire logic copper_link_down_i,
  input wire logic copper_full_duplex_i,
  input wire logic copper_speed_100_i,
  input wire logic optical_signal_absent_i,
  input wire logic optical_link_up_i,
  // Maintenance frame engine
  input wire logic rx_frame_valid_i,
  input wire osr_pkg::osr_frame_type rx_frame_i,
  output osr_pkg::osr_frame_type tx_frame_o
);
  import osr_pkg::*;

  osr_state_type s;
  osr_state_type next_s;
  logic role_t;
  logic [7:0] low_wmask;

  // ==========================================================================
  // Register read decode
  function automatic logic [32:0] osr_read(input osr_state_type st, input logic [11:0] addr);
    logic [7:0] idx;
    logic [32:0] res;
    idx = addr[9:2];
    res = {1'b0, 32'h00000000};
    if (addr[11:10] == 2'b00 && addr[1:0] == 2'b00) begin
      res[32] = 1'b1;
      unique case (idx)
        OSR_IDX_SHADOW: res[7:0] = st.shadow;
        OSR_IDX_LOC_STAT_LOW: res[7:0] = st.stat_low;
        OSR_IDX_LOC_STAT_HIGH: res[7:0] = st.stat_high;
        OSR_IDX_LOC_VENDOR0: res[7:0] = st.vendor[7:0];
        OSR_IDX_LOC_VENDOR1: res[7:0] = st.vendor[15:8];
        OSR_IDX_LOC_VENDOR2: res[7:0] = st.vendor[23:16];
        OSR_IDX_LOC_MODEL0: res[7:0] = st.model[7:0];
        OSR_IDX_LOC_MODEL1: res[7:0] = st.model[15:8];
        OSR_IDX_LOC_MODEL2: res[7:0] = st.model[23:16];
        OSR_IDX_PART_STAT_LOW: res[7:0] = st.part_low;
        OSR_IDX_PART_STAT_HIGH: res[7:0] = st.part_high;
        OSR_IDX_PART_VENDOR0: res[7:0] = st.part_vendor[7:0];
        OSR_IDX_PART_VENDOR1: res[7:0] = st.part_vendor[15:8];
        OSR_IDX_PART_VENDOR2: res[7:0] = st.part_vendor[23:16];
        OSR_IDX_PART_MODEL0: res[7:0] = st.part_model[7:0];
        OSR_IDX_PART_MODEL1: res[7:0] = st.part_model[15:8];
        OSR_IDX_PART_MODEL2: res[7:0] = st.part_model[23:16];
        default: res[32] = 1'b0;
      endcase
    end
    return res;
  endfunction : osr_read

  // ==========================================================================
  // Next-state logic
  // Straps are caught in the first cycle after reset release, since an
  // asynchronous reset may only load constants.
  assign role_t = s.init_done ? s.role_terminal : role_terminal_i;
  assign low_wmask = role_t ? 8'h00 : OSR_LOW_WMASK_CENTER; // RULE4 RULE7

  always_comb begin
    logic [32:0] rd;
    logic [7:0] wbyte;
    logic [7:0] widx;
    rd = '0;
    wbyte = '0;
    widx = '0;
    next_s = s;

    if (!s.init_done) begin
      next_s.init_done = 1'b1;
      next_s.role_terminal = role_terminal_i;
      next_s.stat_low[OSR_BIT_DIAG_FAIL] = diagnostic_fail_pin_i; // RULE5
      next_s.stat_high[OSR_BIT_AUTONEG] = role_terminal_i & copper_autoneg_strap_i; // RULE11
      next_s.part_low = role_terminal_i ? OSR_PART_LOW_RST_TERMINAL : OSR_PART_LOW_RST_CENTER; // RULE16
      next_s.shadow = next_s.part_low;
    end

    // Hardware-owned status bits.
    next_s.stat_low[7] = 1'b0;
    next_s.stat_low[OSR_BIT_ROLE] = role_t; // RULE1
    next_s.stat_low[OSR_BIT_LOOPBACK] = loopback_state_i; // RULE2
    next_s.stat_low[OSR_BIT_SIG_ABSENT] = optical_signal_absent_i; // RULE8
    next_s.stat_low[OSR_BIT_POWER_DOWN] = ~power_down_pin_n_i; // RULE9
    next_s.stat_high[7:4] = 4'h0; // RULE10
    if (role_t) begin
      next_s.stat_low[OSR_BIT_NOTIFY_SEL] = optical_loss_notify_pin_i; // RULE3 RULE4
      next_s.stat_low[OSR_BIT_DIAG_FAIL] = diagnostic_fail_pin_i; // RULE5
      next_s.stat_low[OSR_BIT_LINK_DOWN] = copper_link_down_i; // RULE6 RULE7
      next_s.stat_high[OSR_BIT_DUPLEX] = copper_full_duplex_i & ~copper_link_down_i; // RULE12
      next_s.stat_high[OSR_BIT_SPEED] = copper_speed_100_i & ~copper_link_down_i; // RULE13
    end else begin
      next_s.stat_high[OSR_BIT_DUPLEX] = 1'b0; // RULE14
      next_s.stat_high[OSR_BIT_SPEED] = 1'b0; // RULE14
    end

    // Partner copies from received maintenance frames.
    if (rx_frame_valid_i) begin
      next_s.part_low = rx_frame_i.status_low; // RULE16
      next_s.part_high = rx_frame_i.status_high; // RULE17
      next_s.part_vendor = rx_frame_i.vendor; // RULE19
      next_s.part_model = rx_frame_i.model; // RULE19
    end
    if (optical_link_up_i) begin
      next_s.shadow = next_s.part_low; // RULE18
    end

    // Every transmitted frame carries the current local bytes.
    next_s.tx_frame.status_low = s.stat_low; // RULE20
    next_s.tx_frame.status_high = s.stat_high; // RULE20
    next_s.tx_frame.vendor = s.vendor; // RULE20
    next_s.tx_frame.model = s.model; // RULE20

    // AXI4-Lite write: address and data are taken in either order.
    if (s_axi_awvalid_i && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata_i;
      next_s.wstrb = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      rd = osr_read(s, s.awaddr);
      wbyte = s.wdata[7:0];
      widx = s.awaddr[9:2];
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = rd[32] ? OSR_RESP_OKAY : OSR_RESP_SLVERR;
      // Only byte lane 0 holds data; writes to read-only registers are ignored.
      if (rd[32] && s.wstrb[0]) begin
        unique case (widx)
          OSR_IDX_LOC_STAT_LOW:
            next_s.stat_low = (next_s.stat_low & ~low_wmask) | (wbyte & low_wmask); // RULE4 RULE7
          OSR_IDX_LOC_STAT_HIGH:
            next_s.stat_high = (next_s.stat_high & ~OSR_HIGH_WMASK) | (wbyte & OSR_HIGH_WMASK); // RULE10 RULE11
          OSR_IDX_LOC_VENDOR0: next_s.vendor[7:0] = wbyte;
          OSR_IDX_LOC_VENDOR1: next_s.vendor[15:8] = wbyte;
          OSR_IDX_LOC_VENDOR2: next_s.vendor[23:16] = wbyte;
          OSR_IDX_LOC_MODEL0: next_s.model[7:0] = wbyte; // RULE15
          OSR_IDX_LOC_MODEL1: next_s.model[15:8] = wbyte;
          OSR_IDX_LOC_MODEL2: next_s.model[23:16] = wbyte;
          default: next_s.bresp = OSR_RESP_OKAY;
        endcase
      end
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // AXI4-Lite read: answered at the edge that takes the address.
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arready) begin
      rd = osr_read(s, s_axi_araddr_i);
      next_s.rvalid = 1'b1;
      next_s.rdata = rd[31:0];
      next_s.rresp = rd[32] ? OSR_RESP_OKAY : OSR_RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.stat_low <= OSR_LOC_LOW_RST; // RULE6 RULE8
      s.stat_high <= OSR_LOC_HIGH_RST;
      s.vendor <= OSR_INFO_RST;
      s.model <= OSR_INFO_RST;
      s.part_low <= OSR_PART_LOW_RST_TERMINAL;
      s.part_high <= OSR_PART_HIGH_RST; // RULE17
      s.shadow <= OSR_PART_LOW_RST_TERMINAL;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o = s.wready;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rresp_o = s.rresp;
  assign s_axi_rdata_o = s.rdata;
  assign tx_frame_o = s.tx_frame;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence init_edge_s;
    $rose(s.init_done);
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid_i && s.arready;
  endsequence
  sequence wr_ready_s;
    s.aw_got && s.w_got && !s.bvalid;
  endsequence

  role_flag_a: assert property (s.init_done |-> s.stat_low[OSR_BIT_ROLE] == s.role_terminal) // RULE1
    else $error("Role flag differs from captured role.");
  loopback_flag_a: assert property (s.init_done |=> s.stat_low[OSR_BIT_LOOPBACK] == $past(loopback_state_i)) // RULE2
    else $error("Loopback flag does not track input.");
  notify_pin_a: assert property (s.init_done && s.role_terminal
      |=> s.stat_low[OSR_BIT_NOTIFY_SEL] == $past(optical_loss_notify_pin_i)) // RULE3
    else $error("Terminal notify select does not follow pin.");
  diag_follow_a: assert property (init_edge_s |-> s.stat_low[OSR_BIT_DIAG_FAIL] == $past(diagnostic_fail_pin_i)) // RULE5
    else $error("Diagnostic flag not loaded from pin at release.");
  link_down_a: assert property (s.init_done && s.role_terminal
      |=> s.stat_low[OSR_BIT_LINK_DOWN] == $past(copper_link_down_i)) // RULE6
    else $error("Terminal copper-down flag does not follow hardware.");
  sig_absent_a: assert property (s.init_done |=> s.stat_low[OSR_BIT_SIG_ABSENT] == $past(optical_signal_absent_i)) // RULE8
    else $error("Optical absent flag does not follow input.");
  power_down_a: assert property (resetn_i |=> s.stat_low[OSR_BIT_POWER_DOWN] == !$past(power_down_pin_n_i)) // RULE9
    else $error("Power-down flag is not inverse of pin.");
  reserved_high_a: assert property (s.init_done |-> s.stat_high[7:4] == 4'h0) // RULE10
    else $error("Reserved status bits are not zero.");
  autoneg_strap_a: assert property (init_edge_s
      |-> s.stat_high[OSR_BIT_AUTONEG] == ($past(role_terminal_i) && $past(copper_autoneg_strap_i))) // RULE11
    else $error("Autoneg bit not loaded from strap.");
  duplex_gate_a: assert property (s.init_done && (s.stat_high[OSR_BIT_DUPLEX] || s.stat_high[OSR_BIT_SPEED])
      |-> s.role_terminal && !s.stat_low[OSR_BIT_LINK_DOWN]) // RULE12
    else $error("Duplex or speed set while link down or in center role.");
  center_zero_a: assert property (s.init_done && !s.role_terminal |-> s.stat_high[1:0] == 2'b00) // RULE14
    else $error("Center role shows duplex or speed.");
  partner_reset_a: assert property (init_edge_s and $past(!rx_frame_valid_i)
      |-> s.part_low == ($past(role_terminal_i) ? OSR_PART_LOW_RST_TERMINAL : OSR_PART_LOW_RST_CENTER)) // RULE16
    else $error("Partner status reset value wrong for role.");
  partner_high_a: assert property (init_edge_s and $past(!rx_frame_valid_i) |-> s.part_high == 8'h00) // RULE17
    else $error("Partner status high reset value wrong.");
  shadow_mirror_a: assert property (optical_link_up_i |=> s.shadow == s.part_low) // RULE18
    else $error("Shadow does not mirror partner status.");
  partner_load_a: assert property (rx_frame_valid_i
      |=> s.part_vendor == $past(rx_frame_i.vendor) && s.part_model == $past(rx_frame_i.model)) // RULE19
    else $error("Partner info not loaded from frame.");
  tx_copy_a: assert property (s.init_done
      |=> tx_frame_o.vendor == $past(s.vendor) && tx_frame_o.status_low == $past(s.stat_low)) // RULE20
    else $error("Transmit frame does not carry local bytes.");
  read_answer_a: assert property (rd_taken_s |=> s_axi_rvalid_o ##0 !s_axi_arready_o)
    else $error("Read not answered one edge after address.");
  write_answer_a: assert property (wr_ready_s |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
    else $error("Write response not raised.");

endmodule : osr_regs

// *** tb/osr_far_end.sv ***
// Behavioural model of the remote converter that sends maintenance frames.
// Assumes the bench asks for a frame with a one-cycle request on send_i.
`timescale 1ns/1ps
module osr_far_end
  import osr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Bench request
  input wire logic send_i,
  input wire osr_pkg::osr_frame_type frame_i,
  // Frame link towards the bank
  output logic valid_o,
  output osr_pkg::osr_frame_type frame_o
);
  osr_frame_type last;
  // ==========================================================================
  // Frame output
  // Outside a frame the data lines show the inverse of the last frame.
  // A stale copy could otherwise hide a bank that samples without the pulse.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      frame_o <= '1;
      last <= '0;
    end else if (send_i) begin
      valid_o <= 1'b1;
      frame_o <= frame_i;
      last <= frame_i;
    end else begin
      valid_o <= 1'b0;
      frame_o <= ~last;
    end
  end
endmodule : osr_far_end

// *** tb/tb_top.sv ***
// Self-checking bench of the maintenance status register bank.
// Assumes the bank answers on AXI4-Lite and the far end model feeds frames.
`timescale 1ns/1ps
module tb_top;
  import osr_pkg::*;
  logic clk, rstn, awv, wv, bv, brdy, arv, rv, rrdy, awr, wr_rdy, arr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] br, rr;
  logic role, loop, notify, diag, pdn_n, strap, cdown, dup, spd, sabs, olink, send, fv;
  osr_frame_type ff, fo, tx;
  int errors, compares;
  osr_regs i_osr_regs (.core_clk_i(clk), .resetn_i(rstn), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy), .role_terminal_i(role),
    .loopback_state_i(loop), .optical_loss_notify_pin_i(notify), .diagnostic_fail_pin_i(diag),
    .power_down_pin_n_i(pdn_n), .copper_autoneg_strap_i(strap), .copper_link_down_i(cdown),
    .copper_full_duplex_i(dup), .copper_speed_100_i(spd), .optical_signal_absent_i(sabs),
    .optical_link_up_i(olink), .rx_frame_valid_i(fv), .rx_frame_i(fo), .tx_frame_o(tx));
  osr_far_end i_osr_far_end (.core_clk_i(clk), .resetn_i(rstn), .send_i(send), .frame_i(ff),
    .valid_o(fv), .frame_o(fo));
  // ==========================================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // Write one register; the byte address is four times the index.
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awa <= {2'b00, idx, 2'b00};
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) break;
    end
    if (n == 20) errors++;
    brdy <= 1'b0;
    chk({30'h0, br}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] idx, input logic [7:0] ev, input logic [1:0] er);
    int n;
    @(posedge clk);
    ara <= {2'b00, idx, 2'b00};
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (n == 20) errors++;
    rrdy <= 1'b0;
    chk(rd, {24'h000000, ev});
    chk({30'h0, rr}, {30'h0, er});
  endtask : axi_rd
  task automatic reset_as(input logic r);
    @(posedge clk);
    rstn <= 1'b0;
    role <= r;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : reset_as
  task automatic frame(input osr_frame_type f);
    @(posedge clk);
    ff <= f;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : frame
  // ==========================================================================
  // Tests
  initial begin
    logic [47:0] vm;
    osr_frame_type f1;
    {awv, wv, brdy, arv, rrdy, send, rstn} = '0;
    {awa, ara, wd, ws, ff} = '0;
    ws = 4'h1;
    {role, loop, notify, diag, pdn_n, strap, cdown, dup, spd, sabs, olink} = 11'b01111101111;
    errors = 0;
    compares = 0;
    f1 = {8'h0d, 8'h4a, 24'h123456, 24'h9abcde};
    // Center role first.
    reset_as(1'b0);
    axi_rd(OSR_IDX_LOC_STAT_LOW, 8'h2e, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_LOC_STAT_HIGH, 8'h00, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_PART_STAT_LOW, 8'h47, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_SHADOW, 8'h47, OSR_RESP_OKAY);
    for (int i = 1; i < 8; i++) axi_rd(8'(OSR_IDX_PART_STAT_LOW + i), 8'h00, OSR_RESP_OKAY);
    axi_wr(OSR_IDX_LOC_STAT_LOW, 8'hff, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_LOC_STAT_LOW, 8'h3e, OSR_RESP_OKAY);
    sabs <= 1'b0;
    pdn_n <= 1'b0;
    axi_wr(OSR_IDX_LOC_STAT_LOW, 8'h00, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_LOC_STAT_LOW, 8'h21, OSR_RESP_OKAY);
    axi_wr(OSR_IDX_LOC_STAT_HIGH, 8'hff, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_LOC_STAT_HIGH, 8'h0c, OSR_RESP_OKAY);
    axi_wr(OSR_IDX_LOC_STAT_HIGH, 8'h00, OSR_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      vm[8*i+:8] = 8'(8'h81 + 8'h11 * i);
      axi_wr(8'(OSR_IDX_LOC_VENDOR0 + i), vm[8*i+:8], OSR_RESP_OKAY);
      axi_rd(8'(OSR_IDX_LOC_VENDOR0 + i), vm[8*i+:8], OSR_RESP_OKAY);
    end
    chk({8'h00, tx.vendor}, {8'h00, vm[23:0]});
    chk({8'h00, tx.model}, {8'h00, vm[47:24]});
    chk({24'h0, tx.status_low}, 32'h21);
    chk({24'h0, tx.status_high}, 32'h00);
    axi_wr(OSR_IDX_PART_STAT_LOW, 8'hff, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_PART_STAT_LOW, 8'h47, OSR_RESP_OKAY);
    axi_wr(8'h60, 8'h55, OSR_RESP_SLVERR);
    axi_rd(8'h60, 8'h00, OSR_RESP_SLVERR);
    // Frames from the partner, first with the optical link up.
    frame(f1);
    vm = {f1.model, f1.vendor};
    axi_rd(OSR_IDX_PART_STAT_LOW, 8'h4a, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_PART_STAT_HIGH, 8'h0d, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_SHADOW, 8'h4a, OSR_RESP_OKAY);
    for (int i = 0; i < 6; i++) axi_rd(8'(OSR_IDX_PART_VENDOR0 + i), vm[8*i+:8], OSR_RESP_OKAY);
    olink <= 1'b0;
    frame({8'h00, 8'h41, 48'h0});
    axi_rd(OSR_IDX_PART_STAT_LOW, 8'h41, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_SHADOW, 8'h4a, OSR_RESP_OKAY);
    // Terminal role: pins now drive the status words.
    {loop, diag, sabs} <= 3'b000;
    reset_as(1'b1);
    axi_rd(OSR_IDX_LOC_STAT_LOW, 8'h51, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_LOC_STAT_HIGH, 8'h07, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_PART_STAT_LOW, 8'h07, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_SHADOW, 8'h07, OSR_RESP_OKAY);
    axi_wr(OSR_IDX_LOC_STAT_LOW, 8'h00, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_LOC_STAT_LOW, 8'h51, OSR_RESP_OKAY);
    {cdown, diag, notify} <= 3'b110;
    axi_rd(OSR_IDX_LOC_STAT_LOW, 8'h4d, OSR_RESP_OKAY);
    axi_rd(OSR_IDX_LOC_STAT_HIGH, 8'h04, OSR_RESP_OKAY);
    {cdown, spd} <= 2'b00;
    axi_rd(OSR_IDX_LOC_STAT_HIGH, 8'h06, OSR_RESP_OKAY);
    tally_and_finish();
  end
endmodule : tb_top
